// [sfpoc_pkg.sv]
// Constants and types for the frame pulse and analog loop output control
package sfpoc_pkg;
  localparam logic [7:0] ADDR_FMT = 8'h3f;
  localparam logic [7:0] ADDR_OFS_LO = 8'h40;
  localparam logic [7:0] ADDR_OFS_MID = 8'h41;
  localparam logic [7:0] ADDR_OFS_HI = 8'h42;
  localparam logic [7:0] ADDR_APLL_EN = 8'h50;
  localparam logic [7:0] ADDR_APLL_RUN = 8'h51;
  localparam logic [7:0] RST_FMT = 8'h83;
  localparam logic [7:0] RST_OFS = 8'h00;
  localparam logic [7:0] RST_APLL_EN = 8'h8f;
  localparam logic [7:0] RST_APLL_RUN = 8'h0f;
  // Writable bits; every other bit keeps its reset value
  localparam logic [7:0] WM_FMT = 8'hf3;
  localparam logic [7:0] WM_OFS = 8'hff;
  localparam logic [7:0] WM_OFS_HI = 8'h3f;
  localparam logic [7:0] WM_APLL_EN = 8'h81;
  localparam logic [7:0] WM_APLL_RUN = 8'h71;
  localparam int FMT_STYLE = 0;
  localparam int FMT_EDGE = 1;
  localparam int FMT_WLSB = 4;
  localparam int FMT_WMSB = 6;
  localparam int FMT_POL = 7;
  localparam int OFS_FINE_W = 16;
  localparam int OFS_W = 22;
  localparam int EN_OUT = 0;
  localparam int EN_PWR = 7;
  localparam int RUN_CLK = 0;
  localparam int RUN_FSEL = 4;
  localparam int RUN_FDIFF = 5;
  localparam int RUN_ETH = 6;
  localparam logic [2:0] WCODE_MAX = 3'h4;
  localparam logic [2:0] WCODE_CLK = 3'h7;
  // Fine ticks per pulse for code 000; each code step halves it
  localparam logic [6:0] FINE_TICKS_BASE = 7'h40;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ONE_HZ_PULSE_NS = 4000000;
  localparam int unsigned ONE_HZ_PULSE_CYC = ONE_HZ_PULSE_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE, ST_COARSE, ST_FINE, ST_ARM, ST_PULSE, ST_LONG
  } sfpoc_fp_e;
  function automatic logic [7:0] keep_rsvd(input logic [7:0] wr,
                                           input logic [7:0] msk,
                                           input logic [7:0] rst);
    return (wr & msk) | (rst & ~msk);
  endfunction
endpackage

// [sfpoc_cfg_if.sv]
// Register fields carried from the register file to the output core
`timescale 1ns/1ns
interface sfpoc_cfg_if;
  logic [7:0] fmt;
  logic [21:0] ofs;
  logic [7:0] apll_en;
  logic [7:0] apll_run;
  modport regs(output fmt, ofs, apll_en, apll_run);
  modport core(input fmt, ofs, apll_en, apll_run);
endinterface

// [sfpoc_regs.sv]
// Byte register file for the frame pulse and analog loop controls
`timescale 1ns/1ns
module sfpoc_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  sfpoc_cfg_if.regs cfg
);
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] lo;
    logic [7:0] mid;
    logic [7:0] hi;
    logic [7:0] en;
    logic [7:0] run;
    logic [7:0] rdata;
  } sfpoc_regs_s;

  localparam sfpoc_regs_s REGS_RST = '{
    fmt: sfpoc_pkg::RST_FMT, lo: sfpoc_pkg::RST_OFS,
    mid: sfpoc_pkg::RST_OFS, hi: sfpoc_pkg::RST_OFS,
    en: sfpoc_pkg::RST_APLL_EN, run: sfpoc_pkg::RST_APLL_RUN,
    rdata: 8'h00};

  sfpoc_regs_s q;
  sfpoc_regs_s d;

  always_comb begin
    d = q;
    if (reg_wr) begin
      // Reserved fields ignore writes and keep their defaults
      case (reg_addr)
        sfpoc_pkg::ADDR_FMT: d.fmt = sfpoc_pkg::keep_rsvd(reg_wdata,
          sfpoc_pkg::WM_FMT, sfpoc_pkg::RST_FMT);
        sfpoc_pkg::ADDR_OFS_LO: d.lo = reg_wdata;
        sfpoc_pkg::ADDR_OFS_MID: d.mid = reg_wdata;
        sfpoc_pkg::ADDR_OFS_HI: d.hi = sfpoc_pkg::keep_rsvd(reg_wdata,
          sfpoc_pkg::WM_OFS_HI, sfpoc_pkg::RST_OFS);
        sfpoc_pkg::ADDR_APLL_EN: d.en = sfpoc_pkg::keep_rsvd(reg_wdata,
          sfpoc_pkg::WM_APLL_EN, sfpoc_pkg::RST_APLL_EN);
        sfpoc_pkg::ADDR_APLL_RUN: d.run = sfpoc_pkg::keep_rsvd(reg_wdata,
          sfpoc_pkg::WM_APLL_RUN, sfpoc_pkg::RST_APLL_RUN);
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        sfpoc_pkg::ADDR_FMT: d.rdata = q.fmt;
        sfpoc_pkg::ADDR_OFS_LO: d.rdata = q.lo;
        sfpoc_pkg::ADDR_OFS_MID: d.rdata = q.mid;
        sfpoc_pkg::ADDR_OFS_HI: d.rdata = q.hi;
        sfpoc_pkg::ADDR_APLL_EN: d.rdata = q.en;
        sfpoc_pkg::ADDR_APLL_RUN: d.rdata = q.run;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign cfg.fmt = q.fmt;
  // Three bytes form one offset word
  assign cfg.ofs = {q.hi[5:0], q.mid, q.lo};
  assign cfg.apll_en = q.en;
  assign cfg.apll_run = q.run;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ofs_hi;
    (reg_wr && reg_addr == sfpoc_pkg::ADDR_OFS_HI)
      |=> cfg.ofs[21:16] == 6'($past(reg_wdata)) && $stable(cfg.ofs[15:0]);
  endproperty
  a_ofs_hi: assert property (p_ofs_hi)
    else $error("offset high byte not placed in bits 21:16");

  property p_rsvd;
    ((cfg.fmt & ~sfpoc_pkg::WM_FMT) == (sfpoc_pkg::RST_FMT & ~sfpoc_pkg::WM_FMT))
      && ((cfg.apll_en & ~sfpoc_pkg::WM_APLL_EN)
          == (sfpoc_pkg::RST_APLL_EN & ~sfpoc_pkg::WM_APLL_EN))
      && ((cfg.apll_run & ~sfpoc_pkg::WM_APLL_RUN)
          == (sfpoc_pkg::RST_APLL_RUN & ~sfpoc_pkg::WM_APLL_RUN));
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved field left its default");

  property p_rd_en;
    (reg_rd && !reg_wr && reg_addr == sfpoc_pkg::ADDR_APLL_EN)
      |=> reg_rdata == cfg.apll_en;
  endproperty
  a_rd_en: assert property (p_rd_en)
    else $error("read of enable register returned wrong value");
endmodule

// [sfpoc_top.sv]
// Frame pulse generator and analog loop output control with registers
//
// Functional notes
// - Style 0: output follows clock with its own duty; at 1 Hz pulse is 4 ms.
// - Style 1: output is a frame pulse aligned to the E1-family frame.
// - Sync edge bit picks rising (0) or falling (1) edge; ignored at 1 Hz.
// - Width codes 000-100 give one period of 4.096 to 65.536 MHz.
// - Width code 111 makes the pulse one programmable clock cycle long.
// - Format bit 7 sets polarity: 0 positive pulses, 1 negative pulses.
// - Phase offset is 22 bits from three byte registers.
// - Lower sixteen offset bits delay in 262.144 MHz periods.
// - Upper six offset bits shift in whole 8 kHz cycles.
// - Enable bit 0 drives the analog loop clock, else high impedance.
// - Enable bit 7 switches the analog loop on or off.
// - Run bit lets the analog loop clock toggle, else holds it low.
// - Bit 4 with the Ethernet bit picks single-ended frequency group.
// - Bit 5 picks differential group: 0 high speed, 1 low speed.
// - Bit 6 makes the analog loop produce telecom or Ethernet rates.
// - Programmable output is driven when its enable is set, else floats.
`timescale 1ns/1ns
module sfpoc_top #(
  parameter int unsigned ONE_HZ_CYC = sfpoc_pkg::ONE_HZ_PULSE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic prog_clk_src,
  input wire logic frame_tick,
  input wire logic fine_tick,
  input wire logic one_hz_sel,
  input wire logic prog_out_en,
  input wire logic apll_clk_src,
  output logic prog_out_o,
  output logic prog_out_oe,
  output logic apll_clk_o,
  output logic apll_clk_oe,
  output logic apll_power_on,
  output logic apll_se_ethernet,
  output logic diff_low_speed,
  output logic apll_eth_mode
);
  typedef struct packed {
    sfpoc_pkg::sfpoc_fp_e st;
    logic [5:0] coarse;
    logic [15:0] fine;
    logic [23:0] wcnt;
    logic clk_prev;
    logic fp;
    logic prog_o;
    logic prog_oe;
    logic apll_o;
    logic apll_oe;
  } sfpoc_core_s;

  localparam sfpoc_core_s CORE_RST = '{
    st: sfpoc_pkg::ST_IDLE, coarse: 6'h00, fine: 16'h0000,
    wcnt: 24'h000000, clk_prev: 1'b0, fp: 1'b0, prog_o: 1'b0,
    prog_oe: 1'b0, apll_o: 1'b0, apll_oe: 1'b0};

  sfpoc_cfg_if cfg();

  sfpoc_regs u_regs (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cfg(cfg.regs)
  );

  sfpoc_core_s q;
  sfpoc_core_s d;
  logic style;
  logic sedge;
  logic pol;
  logic [2:0] wcode;
  logic rise;
  logic fall;
  logic edge_hit;
  logic oe_bit;
  logic pwr_bit;
  logic run_bit;

  assign style = cfg.fmt[sfpoc_pkg::FMT_STYLE];
  assign sedge = cfg.fmt[sfpoc_pkg::FMT_EDGE];
  assign pol = cfg.fmt[sfpoc_pkg::FMT_POL];
  assign wcode = cfg.fmt[sfpoc_pkg::FMT_WMSB:sfpoc_pkg::FMT_WLSB];
  assign oe_bit = cfg.apll_en[sfpoc_pkg::EN_OUT];
  assign pwr_bit = cfg.apll_en[sfpoc_pkg::EN_PWR];
  assign run_bit = cfg.apll_run[sfpoc_pkg::RUN_CLK];

  assign rise = prog_clk_src & ~q.clk_prev;
  assign fall = ~prog_clk_src & q.clk_prev;
  // At 1 Hz the edge choice does not apply; rising is used
  assign edge_hit = (one_hz_sel | ~sedge) ? rise : fall;

  always_comb begin
    d = q;
    d.clk_prev = prog_clk_src;
    if (!style) begin
      if (!one_hz_sel) begin
        // Plain clock: the synthesized clock passes with its own duty
        d.st = sfpoc_pkg::ST_IDLE;
        d.fp = prog_clk_src;
      end else if (q.st == sfpoc_pkg::ST_LONG) begin
        if (q.wcnt == 24'h000001) begin
          d.fp = 1'b0;
          d.st = sfpoc_pkg::ST_IDLE;
        end else begin
          d.wcnt = 24'(q.wcnt - 24'h000001);
        end
      end else begin
        d.fp = 1'b0;
        d.st = sfpoc_pkg::ST_IDLE;
        if (frame_tick) begin
          d.fp = 1'b1;
          d.st = sfpoc_pkg::ST_LONG;
          d.wcnt = 24'(ONE_HZ_CYC);
        end
      end
    end else begin
      unique case (q.st)
        sfpoc_pkg::ST_IDLE: begin
          d.fp = 1'b0;
          if (frame_tick) begin
            // Coarse shift first, then fine delay, then the sync edge
            if (cfg.ofs[21:16] != 6'h00) begin
              d.st = sfpoc_pkg::ST_COARSE;
              d.coarse = cfg.ofs[21:16];
            end else begin
              d.st = sfpoc_pkg::ST_FINE;
              d.fine = cfg.ofs[15:0];
            end
          end
        end
        sfpoc_pkg::ST_COARSE: begin
          if (frame_tick) begin
            if (q.coarse == 6'h01) begin
              d.st = sfpoc_pkg::ST_FINE;
              d.fine = cfg.ofs[15:0];
            end else begin
              d.coarse = 6'(q.coarse - 6'h01);
            end
          end
        end
        sfpoc_pkg::ST_FINE: begin
          if (q.fine == 16'h0000) begin
            d.st = sfpoc_pkg::ST_ARM;
          end else if (fine_tick) begin
            d.fine = 16'(q.fine - 16'h0001);
          end
        end
        sfpoc_pkg::ST_ARM: begin
          if (edge_hit) begin
            d.fp = 1'b1;
            d.st = sfpoc_pkg::ST_PULSE;
            d.wcnt = 24'(sfpoc_pkg::FINE_TICKS_BASE >> wcode);
          end
        end
        sfpoc_pkg::ST_PULSE: begin
          // Reserved codes behave as code 111
          if (wcode > sfpoc_pkg::WCODE_MAX) begin
            if (edge_hit) begin
              d.fp = 1'b0;
              d.st = sfpoc_pkg::ST_IDLE;
            end
          end else if (fine_tick) begin
            if (q.wcnt == 24'h000001) begin
              d.fp = 1'b0;
              d.st = sfpoc_pkg::ST_IDLE;
            end else begin
              d.wcnt = 24'(q.wcnt - 24'h000001);
            end
          end
        end
        sfpoc_pkg::ST_LONG: begin
          // Left over from a style change
          d.fp = 1'b0;
          d.st = sfpoc_pkg::ST_IDLE;
        end
      endcase
    end
    d.prog_o = q.fp ^ pol;
    d.prog_oe = prog_out_en;
    d.apll_oe = oe_bit;
    // An unpowered or stopped loop holds its clock low
    d.apll_o = apll_clk_src & run_bit & pwr_bit;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign prog_out_o = q.prog_o;
  assign prog_out_oe = q.prog_oe;
  assign apll_clk_o = q.apll_o;
  assign apll_clk_oe = q.apll_oe;
  assign apll_power_on = pwr_bit;
  assign apll_se_ethernet = cfg.apll_run[sfpoc_pkg::RUN_FSEL]
                            & cfg.apll_run[sfpoc_pkg::RUN_ETH];
  assign diff_low_speed = cfg.apll_run[sfpoc_pkg::RUN_FDIFF];
  assign apll_eth_mode = cfg.apll_run[sfpoc_pkg::RUN_ETH];

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_clk_style;
    (!style && !one_hz_sel) ##1 (!style && !one_hz_sel)
      |=> prog_out_o == ($past(prog_clk_src, 2) ^ $past(pol));
  endproperty
  a_clk_style: assert property (p_clk_style)
    else $error("clock style output does not follow the clock");

  property p_one_hz;
    (!style && one_hz_sel && frame_tick && q.st != sfpoc_pkg::ST_LONG)
      |=> q.fp && q.st == sfpoc_pkg::ST_LONG && q.wcnt == 24'(ONE_HZ_CYC);
  endproperty
  a_one_hz: assert property (p_one_hz)
    else $error("1 Hz pulse not started with full width");

  property p_frame_start;
    (style && q.st == sfpoc_pkg::ST_IDLE && frame_tick)
      |=> (q.st == sfpoc_pkg::ST_COARSE || q.st == sfpoc_pkg::ST_FINE);
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame tick did not start the offset delay");

  property p_fall_edge;
    (style && q.st == sfpoc_pkg::ST_ARM && sedge && !one_hz_sel && rise)
      |=> !q.fp && q.st == sfpoc_pkg::ST_ARM;
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("pulse fired on rising edge while falling was chosen");

  property p_width_load;
    (style && q.st == sfpoc_pkg::ST_ARM && edge_hit
      && wcode <= sfpoc_pkg::WCODE_MAX)
      |=> q.fp && q.wcnt == 24'(sfpoc_pkg::FINE_TICKS_BASE >> $past(wcode));
  endproperty
  a_width_load: assert property (p_width_load)
    else $error("pulse width count wrong for width code");

  property p_width_end;
    (style && q.st == sfpoc_pkg::ST_PULSE && wcode <= sfpoc_pkg::WCODE_MAX
      && fine_tick && q.wcnt == 24'h000001)
      |=> !q.fp && q.st == sfpoc_pkg::ST_IDLE;
  endproperty
  a_width_end: assert property (p_width_end)
    else $error("pulse did not end after its width");

  property p_clk_width;
    (style && q.st == sfpoc_pkg::ST_PULSE
      && wcode == sfpoc_pkg::WCODE_CLK && !edge_hit) |=> q.fp;
  endproperty
  a_clk_width: assert property (p_clk_width)
    else $error("clock-wide pulse ended before the next edge");

  property p_pol;
    1'b1 |=> prog_out_o == ($past(q.fp) ^ $past(pol));
  endproperty
  a_pol: assert property (p_pol)
    else $error("output polarity wrong");

  property p_fine;
    (style && q.st == sfpoc_pkg::ST_FINE && q.fine != 16'h0000 && fine_tick)
      |=> q.fine == 16'($past(q.fine) - 16'h0001);
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine offset did not count a fine tick");

  property p_coarse;
    (style && q.st == sfpoc_pkg::ST_COARSE && frame_tick && q.coarse > 6'h01)
      |=> q.st == sfpoc_pkg::ST_COARSE
          && q.coarse == 6'($past(q.coarse) - 6'h01);
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse offset did not count a frame");

  property p_apll_oe;
    1'b1 |=> apll_clk_oe == $past(oe_bit);
  endproperty
  a_apll_oe: assert property (p_apll_oe)
    else $error("analog loop clock enable does not follow bit 0");

  property p_apll_pwr;
    (!pwr_bit && !reg_wr) |=> !apll_power_on ##0 !apll_clk_o;
  endproperty
  a_apll_pwr: assert property (p_apll_pwr)
    else $error("analog loop clock active while powered off");

  property p_apll_run;
    (!run_bit) |=> !apll_clk_o;
  endproperty
  a_apll_run: assert property (p_apll_run)
    else $error("analog loop clock not held low when stopped");

  property p_se_sel;
    (reg_wr && reg_addr == sfpoc_pkg::ADDR_APLL_RUN)
      |=> apll_se_ethernet == ($past(reg_wdata[sfpoc_pkg::RUN_FSEL])
          && $past(reg_wdata[sfpoc_pkg::RUN_ETH]))
          && apll_eth_mode == $past(reg_wdata[sfpoc_pkg::RUN_ETH]);
  endproperty
  a_se_sel: assert property (p_se_sel)
    else $error("single-ended group does not follow the run register write");

  property p_prog_oe;
    (!prog_out_en) |=> !prog_out_oe;
  endproperty
  a_prog_oe: assert property (p_prog_oe)
    else $error("programmable output driven while disabled");
endmodule

// [test_sfpoc_top.sv]
// Self-checking bench for the frame pulse and analog loop output control
`timescale 1ns/1ns
module test_sfpoc_top;
  localparam logic [7:0] ADR [7] = '{sfpoc_pkg::ADDR_FMT, sfpoc_pkg::ADDR_OFS_LO,
    sfpoc_pkg::ADDR_OFS_MID, sfpoc_pkg::ADDR_OFS_HI, sfpoc_pkg::ADDR_APLL_EN,
    sfpoc_pkg::ADDR_APLL_RUN, 8'h43};
  localparam logic [7:0] RSTV [7] = '{sfpoc_pkg::RST_FMT, sfpoc_pkg::RST_OFS,
    sfpoc_pkg::RST_OFS, sfpoc_pkg::RST_OFS, sfpoc_pkg::RST_APLL_EN,
    sfpoc_pkg::RST_APLL_RUN, 8'h00};
  localparam logic [7:0] MSK [7] = '{sfpoc_pkg::WM_FMT, sfpoc_pkg::WM_OFS, sfpoc_pkg::WM_OFS,
    sfpoc_pkg::WM_OFS_HI, sfpoc_pkg::WM_APLL_EN, sfpoc_pkg::WM_APLL_RUN, 8'h00};
  // Short 1 Hz pulse keeps the run brief
  localparam int unsigned HZ_CYC = 20;
  logic clk, nrst, reg_wr, reg_rd, prog_clk_src, frame_tick, fine_tick, one_hz_sel;
  logic prog_out_en, apll_clk_src, prog_out_o, prog_out_oe, apll_clk_o, apll_clk_oe;
  logic apll_power_on, apll_se_ethernet, diff_low_speed, apll_eth_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [7:0] mdl [7];
  int err_total, compares, seed, l0, l, w, i, k;

  sfpoc_top #(.ONE_HZ_CYC(HZ_CYC)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prog_clk_src(prog_clk_src), .frame_tick(frame_tick), .fine_tick(fine_tick),
    .one_hz_sel(one_hz_sel), .prog_out_en(prog_out_en), .apll_clk_src(apll_clk_src),
    .prog_out_o(prog_out_o), .prog_out_oe(prog_out_oe), .apll_clk_o(apll_clk_o),
    .apll_clk_oe(apll_clk_oe), .apll_power_on(apll_power_on),
    .apll_se_ethernet(apll_se_ethernet), .diff_low_speed(diff_low_speed),
    .apll_eth_mode(apll_eth_mode));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Pulse width in fine ticks; reserved codes behave like the clock-cycle code
  function automatic int fp_width(input logic [2:0] c);
    return (c <= sfpoc_pkg::WCODE_MAX) ? (262144 / 4096) >> c : 2;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask

  // Random pin levels; checks clock style, enables and the analog loop clock path
  task automatic cl(input logic [7:0] f, input logic [7:0] en, input logic [7:0] run);
    logic [1:0] s;
    logic e;
    logic a;
    int n;
    wr(sfpoc_pkg::ADDR_FMT, f);
    wr(sfpoc_pkg::ADDR_APLL_EN, en);
    wr(sfpoc_pkg::ADDR_APLL_RUN, run);
    s = 2'h0;
    e = 1'b0;
    a = 1'b0;
    for (n = 0; n < 30; n++) begin
      @(posedge clk);
      #1;
      if (n > 2) begin
        chk(prog_out_o, s[1] ^ f[7]);
        chk(prog_out_oe, e);
        chk(apll_clk_o, a & run[0] & en[7]);
        chk(apll_clk_oe, en[0]);
      end
      prog_clk_src = 1'($random(seed));
      s = {s[0], prog_clk_src};
      prog_out_en = 1'($random(seed));
      e = prog_out_en;
      apll_clk_src = 1'($random(seed));
      a = apll_clk_src;
    end
  endtask

  // One frame sequence with a fast sync clock and a fine tick every cycle
  task automatic fp(input logic [7:0] f, input logic [21:0] o, input logic hz,
      output int lat, output int wid);
    int n;
    wr(sfpoc_pkg::ADDR_FMT, f);
    wr(sfpoc_pkg::ADDR_OFS_LO, o[7:0]);
    wr(sfpoc_pkg::ADDR_OFS_MID, o[15:8]);
    wr(sfpoc_pkg::ADDR_OFS_HI, {2'h0, o[21:16]});
    lat = -1;
    wid = 0;
    for (n = -40; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (n >= 0 && prog_out_o !== f[7]) begin
        if (lat < 0) lat = n;
        wid++;
      end
      one_hz_sel = hz;
      fine_tick = 1'b1;
      prog_clk_src = n[0];
      frame_tick = (n >= 0 && n % 16 == 0 && n / 16 <= int'(o[21:16]));
    end
  endtask

  initial begin
    #(40 * 40000);
    err_total++;
    final_report;
  end

  initial begin
    seed = 32'hc1e6;
    err_total = 0;
    compares = 0;
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    prog_clk_src = 1'b0;
    frame_tick = 1'b0;
    fine_tick = 1'b0;
    one_hz_sel = 1'b0;
    prog_out_en = 1'b0;
    apll_clk_src = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    chk(prog_out_oe, 1'b0);
    chk(apll_clk_oe, 1'b0);
    chk(apll_power_on, 1'b1);
    chk(prog_out_o, 1'b0);
    chk(apll_clk_o, 1'b0);
    chk(apll_eth_mode, 1'b0);
    chk(reg_rdata, 8'h00);
    nrst = 1'b1;
    for (i = 0; i < 7; i++) begin
      mdl[i] = RSTV[i];
      rd(ADR[i], d);
      chk(d, RSTV[i]);
    end
    // All-ones first exposes reserved bits, then random bytes anywhere
    for (i = 0; i < 40; i++) begin
      k = (i < 7) ? i : int'({$random(seed)} % 7);
      d = (i < 7) ? 8'hff : 8'($random(seed));
      fine_tick = 1'($random(seed));
      wr(ADR[k], d);
      mdl[k] = (d & MSK[k]) | (RSTV[k] & ~MSK[k]);
      rd(ADR[k], d);
      chk(d, mdl[k]);
      chk(apll_power_on, mdl[4][7]);
      chk(apll_se_ethernet, mdl[5][4] & mdl[5][6]);
      chk(diff_low_speed, mdl[5][5]);
      chk(apll_eth_mode, mdl[5][6]);
    end
    cl(8'h00, 8'h81, 8'h01);
    cl(8'h80, 8'h01, 8'h71);
    cl(8'h00, 8'h80, 8'h00);
    cl(8'h80, 8'h81, 8'h0f);
    fp(8'h41, 22'h0, 1'b0, l0, w);
    chk(w, fp_width(3'h4));
    for (i = 0; i < 8; i++) begin
      fp({1'b0, 3'(i), 4'h1}, 22'h0, 1'b0, l, w);
      chk(w, fp_width(3'(i)));
    end
    // Sync clock here is clk/2, not an E1 multiple, so software picks code 111
    fp(8'h71, 22'h0, 1'b0, l, w);
    chk(w, fp_width(sfpoc_pkg::WCODE_CLK));
    fp(8'hc1, 22'h0, 1'b0, l, w);
    chk(l, l0);
    chk(w, fp_width(3'h4));
    k = 2 * int'({$random(seed)} % 20) + 2;
    fp(8'h41, 22'(k), 1'b0, l, w);
    chk(l, l0 + k);
    fp(8'h41, 22'h020000, 1'b0, l, w);
    chk(l, l0 + 32);
    fp(8'h41, 22'h010102, 1'b0, l, w);
    chk(l, l0 + 16 + 258);
    fp(8'h43, 22'h0, 1'b0, l, w);
    chk((l == l0 + 1) || (l == l0 - 1), 1'b1);
    // An odd fine offset arms just after a falling edge, so it waits a sync period
    fp(8'h43, 22'h1, 1'b0, l, w);
    chk(l, l0 + 1);
    fp(8'h41, 22'h0, 1'b1, l0, w);
    fp(8'h43, 22'h0, 1'b1, l, w);
    chk(l, l0);
    fp(8'h00, 22'h0, 1'b1, l, w);
    chk(w, HZ_CYC);
    // Mid-run reset must bring every register back to its default
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00);
    chk(prog_out_oe, 1'b0);
    nrst = 1'b1;
    for (i = 0; i < 7; i++) begin
      rd(ADR[i], d);
      chk(d, RSTV[i]);
    end
    final_report;
  end
endmodule
